// File: cte_cache_test_error.sv
/*
  Cache test control register and cache error capture register, reached
  by coprocessor moves, plus routing of indexed cache maintenance ops.
  Assumes all inputs come from core logic on ref_clk; parity checkers
  raise a one-cycle error pulse per side with the error description.
*/
`include "cte_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cte_cache_test_error #(
  parameter int WS_BITS = `CTE_WS_BITS,
  parameter int IDX_W = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Coprocessor move port
  input wire logic [4:0] cop_sel,
  input wire logic cop_wr,
  input wire logic [31:0] cop_wdata,
  output logic [31:0] cop_rdata,
  // Indexed cache operation request
  input wire cte_pkg::cte_op_e cache_op,
  input wire cte_pkg::cte_index_t cache_index,
  input wire logic [31:0] tag_holding_reg,
  input wire logic [31:0] data_holding_reg,
  input wire logic [WS_BITS-1:0] ws_rdata,
  // Cache array strobes
  output logic tag_ram_we,
  output logic tag_ram_re,
  output logic ws_ram_we,
  output logic ws_ram_re,
  output logic [WS_BITS-1:0] ws_wdata,
  output logic data_ram_we,
  output logic [31:0] data_wdata,
  output logic [IDX_W-1:0] ram_index,
  output logic op_refused,
  output logic [WS_BITS-1:0] ws_load_data,
  // Instruction-side error report
  input wire logic ierr_valid,
  input wire logic ierr_level,
  input wire logic ierr_data_ram,
  input wire logic ierr_tag_ram,
  input wire logic ierr_external,
  input wire logic ierr_fatal,
  input wire logic ierr_scratchpad,
  input wire logic ierr_way_ram,
  input wire cte_pkg::cte_way_t ierr_way,
  input wire cte_pkg::cte_index_t ierr_index,
  // Data-side error report
  input wire logic derr_valid,
  input wire logic derr_level,
  input wire logic derr_data_ram,
  input wire logic derr_tag_ram,
  input wire logic derr_external,
  input wire logic derr_fatal,
  input wire logic derr_scratchpad,
  input wire logic derr_way_ram,
  input wire cte_pkg::cte_way_t derr_way,
  input wire cte_pkg::cte_index_t derr_index,
  // Status
  output logic way_select_test
);
  import cte_pkg::*;

  logic wst_q;
  logic [31:0] err_q;
  logic [31:0] err_d;
  logic [31:0] test_ctrl_rd;
  logic wr_test;
  logic wr_err;
  logic cap_en;
  logic use_i;
  logic sel_data_ram;
  logic sel_tag_ram;
  logic sel_sp;
  logic [IDX_W-1:0] cap_index;
  logic [IDX_W-1:0] cap_index_masked;
  logic [1:0] cap_way;
  logic [WS_BITS-1:0] ws_load_d;
  logic [WS_BITS-1:0] ws_load_q;
  logic [31:0] data_wdata_q;

  assign wr_test = cop_wr && (cop_sel == `CTE_SEL_TEST_CTRL);
  assign wr_err = cop_wr && (cop_sel == `CTE_SEL_ERR_CAP);

  // Only the way-select test bit exists; the rest reads zero.
  assign test_ctrl_rd = {2'h0, wst_q, 29'h0000_0000};
  assign way_select_test = wst_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_q <= 1'(`CTE_TEST_CTRL_RESET >> `CTE_WST_BIT);
    end else if (wr_test) begin
      wst_q <= cop_wdata[`CTE_WST_BIT];
    end
  end

  // Tag ops are steered to the way-select RAM in test mode.
  assign tag_ram_we = (cache_op == CTE_OP_STORE_TAG) && !wst_q;
  assign tag_ram_re = (cache_op == CTE_OP_LOAD_TAG) && !wst_q;
  assign ws_ram_we = (cache_op == CTE_OP_STORE_TAG) && wst_q;
  assign ws_ram_re = (cache_op == CTE_OP_LOAD_TAG) && wst_q;
  // Way-select data rides in the low bits of the line address field.
  assign ws_wdata = tag_holding_reg[10 +: WS_BITS];
  assign ws_load_d = ws_ram_re ? ws_rdata : ws_load_q;
  assign ws_load_data = ws_load_q;
  assign ram_index = cache_index[IDX_W-1:0];

  // Store-data is a test-only op; outside test mode it is refused.
  assign data_ram_we = (cache_op == CTE_OP_STORE_DATA) && wst_q;
  assign op_refused = (cache_op == CTE_OP_STORE_DATA) && !wst_q;
  assign data_wdata = data_wdata_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ws_load_q <= '0;
      data_wdata_q <= 32'h0000_0000;
    end else begin
      ws_load_q <= ws_load_d;
      data_wdata_q <= data_holding_reg;
    end
  end

  // When both sides fail together the instruction side fills the fields.
  assign cap_en = ierr_valid || derr_valid;
  assign use_i = ierr_valid;
  assign sel_data_ram = use_i ? ierr_data_ram : derr_data_ram;
  assign sel_tag_ram = use_i ? ierr_tag_ram : derr_tag_ram;
  assign sel_sp = use_i ? ierr_scratchpad : derr_scratchpad;
  assign cap_index = use_i ? ierr_index[IDX_W-1:0] : derr_index[IDX_W-1:0];
  // Upper index bits carry meaning only for scratchpad errors.
  assign cap_index_masked = sel_sp ? cap_index :
    (cap_index & ((IDX_W'(1) << `CTE_SP_INDEX_LSB) - IDX_W'(1)));
  // The way is meaningless for tag or scratchpad errors; report zero.
  assign cap_way = (sel_tag_ram || sel_sp) ? 2'h0 :
    (use_i ? ierr_way : derr_way);

  always_comb begin
    err_d = 32'h0000_0000;
    err_d[`CTE_ER_BIT] = !use_i;
    err_d[`CTE_EC_BIT] = use_i ? ierr_level : derr_level;
    err_d[`CTE_ED_BIT] = sel_data_ram;
    err_d[`CTE_ET_BIT] = sel_tag_ram;
    err_d[`CTE_ES_BIT] = use_i ? ierr_external : derr_external;
    err_d[`CTE_EB_BIT] = ierr_valid && derr_valid;
    err_d[`CTE_EF_BIT] = use_i ? ierr_fatal : derr_fatal;
    err_d[`CTE_SP_BIT] = sel_sp;
    err_d[`CTE_EW_BIT] = use_i ? ierr_way_ram : derr_way_ram;
    err_d[`CTE_WAY_LSB +: 2] = cap_way;
    err_d[IDX_W-1:0] = cap_index_masked;
  end

  // Software writes to the capture register are ignored so the
  // description stays stable until the next exception.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= `CTE_ERR_CAP_RESET;
    end else if (cap_en) begin
      err_q <= err_d;
    end
  end

  assign cop_rdata = (cop_sel == `CTE_SEL_TEST_CTRL) ? test_ctrl_rd :
    (cop_sel == `CTE_SEL_ERR_CAP) ? err_q : 32'h0000_0000;

  logic unused_wr_err;
  assign unused_wr_err = wr_err;
endmodule // cte_cache_test_error
`default_nettype wire

// File: cte_defines.svh
/*
  Constants for the cache test control and cache error capture block:
  coprocessor register selectors, bit positions, widths and reset values.
  Assumes the core supplies a decoded coprocessor register number.
*/
// Functional notes
// - With the way-select test bit set, tag load/store index ops hit the way-select RAM.
// - In that mode the low six line address bits carry way-select data.
// - Index store data is accepted only while the way-select test bit is set.
// - Index store data writes the data holding register to the indexed data word.
// - The way-select test bit is read/write at bit 29, reset to zero.
// - All other test control bits read zero and ignore writes.
// - A parity-error exception updates the error capture register fields.
// - Reference kind is one for data, zero for instruction.
// - Cache level is one for non-primary, zero for primary.
// - The data RAM error flag is one only for a data RAM error.
// - The tag RAM error flag is one only for a tag RAM error.
// - Error source is one for an external snoop, zero for internal.
// - Simultaneous errors set the both flag; fields come from the instruction side.
// - The way field names the failing way; invalid for tag or scratchpad errors.
// - The byte-aligned index is reported; top four bits only for scratchpad errors.
// - Fatal flag marks dirty-victim parity errors and write-back miss way errors.
`ifndef CTE_DEFINES_SVH
`define CTE_DEFINES_SVH
`define CTE_SEL_TEST_CTRL 5'h1A
`define CTE_SEL_ERR_CAP 5'h1B
`define CTE_TEST_CTRL_RESET 32'h0000_0000
`define CTE_ERR_CAP_RESET 32'h0000_0000
`define CTE_WST_BIT 29
`define CTE_ER_BIT 31
`define CTE_EC_BIT 30
`define CTE_ED_BIT 29
`define CTE_ET_BIT 28
`define CTE_ES_BIT 27
`define CTE_EB_BIT 25
`define CTE_EF_BIT 24
`define CTE_SP_BIT 23
`define CTE_EW_BIT 22
`define CTE_WAY_LSB 20
`define CTE_WS_BITS 6
`define CTE_SP_INDEX_LSB 16
`endif

// File: cte_pkg.sv
/*
  Types for the cache test and error capture block.
  Assumes cte_defines.svh is compiled with it.
*/
package cte_pkg;
  // Indexed cache maintenance operation as requested by the core logic.
  typedef enum logic [1:0] {
    CTE_OP_NONE = 2'h0,
    CTE_OP_LOAD_TAG = 2'h1,
    CTE_OP_STORE_TAG = 2'h2,
    CTE_OP_STORE_DATA = 2'h3
  } cte_op_e;
  typedef logic [1:0] cte_way_t;
  typedef logic [19:0] cte_index_t;
endpackage

// File: cte_cache_test_error_sva.sv
/*
  Checker for cte_cache_test_error, bound to every instance of it.
  Assumes register selectors from cte_defines.svh.
*/
`include "cte_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cte_chk_sva import cte_pkg::*; (
  // Clock, reset and register port
  input wire logic ref_clk, rst_n, cop_wr,
  input wire logic [4:0] cop_sel,
  input wire logic [31:0] cop_wdata, cop_rdata,
  // Cache operation routing
  input wire cte_op_e cache_op,
  input wire logic tag_ram_we, tag_ram_re, ws_ram_we, ws_ram_re,
  input wire logic data_ram_we, op_refused, way_select_test,
  // Error pulses
  input wire logic ierr_valid, derr_valid
);
  logic tsel, esel, st, sd;
  assign tsel = cop_sel == `CTE_SEL_TEST_CTRL;
  assign esel = cop_sel == `CTE_SEL_ERR_CAP;
  assign st = cache_op == CTE_OP_STORE_TAG;
  assign sd = cache_op == CTE_OP_STORE_DATA;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_wst_wr;
    cop_wr && tsel |=> way_select_test == $past(cop_wdata[`CTE_WST_BIT]);
  endproperty
  a_wst_wr: assert property (p_wst_wr)
    else $error("test bit write lost");
  property p_tc_rd;
    tsel |-> cop_rdata == {2'h0, way_select_test, 29'h0};
  endproperty
  a_tc_rd: assert property (p_tc_rd)
    else $error("test control reads stray bits");
  property p_ws_st;
    st && way_select_test |-> ws_ram_we && !tag_ram_we;
  endproperty
  a_ws_st: assert property (p_ws_st)
    else $error("store tag not routed to way RAM");
  property p_ws_ld;
    cache_op == CTE_OP_LOAD_TAG && way_select_test |-> ws_ram_re && !tag_ram_re;
  endproperty
  a_ws_ld: assert property (p_ws_ld)
    else $error("load tag not routed to way RAM");
  property p_tg_st;
    st && !way_select_test |-> tag_ram_we && !ws_ram_we;
  endproperty
  a_tg_st: assert property (p_tg_st)
    else $error("store tag not routed to tag RAM");
  property p_sd_no;
    sd && !way_select_test |-> op_refused && !data_ram_we;
  endproperty
  a_sd_no: assert property (p_sd_no)
    else $error("store data accepted outside test mode");
  property p_sd_ok;
    sd && way_select_test |-> data_ram_we && !op_refused;
  endproperty
  a_sd_ok: assert property (p_sd_ok)
    else $error("store data refused in test mode");
  property p_hold;
    esel && $past(esel) && !$past(ierr_valid || derr_valid) |-> $stable(cop_rdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("capture changed without an error");
  property p_both;
    ierr_valid && derr_valid |=> !esel || (cop_rdata[25] && !cop_rdata[31]);
  endproperty
  a_both: assert property (p_both)
    else $error("double error not flagged");
  c_both: cover property (ierr_valid && derr_valid);
  c_sd: cover property (sd && way_select_test);
  c_ref: cover property (op_refused);
endmodule // cte_chk_sva
bind cte_cache_test_error cte_chk_sva u_chk (.*);
`default_nettype wire

// File: test_cache_test_and_error_capture.sv
/*
  Self-checking bench for cte_cache_test_error: registers, op routing
  and error capture. Assumes the checker file is compiled alongside.
*/
`include "cte_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module test_cache_test_and_error_capture;
  import cte_pkg::*;
  logic ref_clk, rst_n, cop_wr, tag_ram_we, tag_ram_re, ws_ram_we, ws_ram_re;
  logic data_ram_we, op_refused, way_select_test, ierr_valid, derr_valid;
  logic ierr_level, ierr_data_ram, ierr_tag_ram, ierr_external, ierr_fatal;
  logic ierr_scratchpad, ierr_way_ram, derr_level, derr_data_ram;
  logic derr_tag_ram, derr_external, derr_fatal, derr_scratchpad, derr_way_ram;
  logic [4:0] cop_sel;
  logic [31:0] cop_wdata, cop_rdata, tag_holding_reg, data_holding_reg;
  logic [31:0] data_wdata;
  logic [5:0] ws_rdata, ws_wdata, ws_load_data;
  logic [19:0] ram_index;
  cte_op_e cache_op;
  cte_way_t ierr_way, derr_way;
  cte_index_t cache_index, ierr_index, derr_index;
  int n_fail, n_tests;
  cte_cache_test_error uut (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [4:0] s, input logic [31:0] d);
    @(negedge ref_clk);
    {cop_sel, cop_wdata, cop_wr} = {s, d, 1'b1};
    @(negedge ref_clk);
    cop_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] s, input logic [31:0] e);
    cop_sel = s;
    #1;
    `CHK(cop_rdata, e)
  endtask
  task automatic op(input cte_op_e o);
    @(negedge ref_clk);
    cache_op = o;
    #1;
  endtask
  // Both sides get opposite fields so a wrong side choice shows.
  task automatic setf(input logic [6:0] f);
    {ierr_level, ierr_data_ram, ierr_tag_ram, ierr_external, ierr_fatal,
      ierr_scratchpad, ierr_way_ram} = f;
    {derr_level, derr_data_ram, derr_tag_ram, derr_external, derr_fatal,
      derr_scratchpad, derr_way_ram} = ~f;
  endtask
  task automatic err(input logic i, input logic d, input logic [6:0] f);
    @(negedge ref_clk);
    setf(f);
    {ierr_valid, derr_valid} = {i, d};
    @(negedge ref_clk);
    {ierr_valid, derr_valid} = 2'b00;
  endtask
  task automatic t_regs;
    rd(`CTE_SEL_TEST_CTRL, `CTE_TEST_CTRL_RESET);
    rd(`CTE_SEL_ERR_CAP, `CTE_ERR_CAP_RESET);
    wr(`CTE_SEL_TEST_CTRL, 32'hFFFF_FFFF);
    rd(`CTE_SEL_TEST_CTRL, 32'h2000_0000);
    wr(`CTE_SEL_ERR_CAP, 32'hFFFF_FFFF);
    rd(`CTE_SEL_ERR_CAP, 32'h0000_0000);
    rd(5'h05, 32'h0000_0000);
    wr(`CTE_SEL_TEST_CTRL, 32'hDFFF_FFFF);
    rd(`CTE_SEL_TEST_CTRL, 32'h0000_0000);
    $display("t_regs finished");
  endtask
  task automatic t_ops;
    op(CTE_OP_STORE_DATA);
    `CHK({op_refused, data_ram_we}, 2'b10)
    op(CTE_OP_STORE_TAG);
    `CHK({tag_ram_we, ws_ram_we}, 2'b10)
    wr(`CTE_SEL_TEST_CTRL, 32'h2000_0000);
    `CHK({tag_ram_we, ws_ram_we, ws_wdata}, {2'b01, tag_holding_reg[15:10]})
    ws_rdata = 6'h2B;
    op(CTE_OP_LOAD_TAG);
    op(CTE_OP_STORE_DATA);
    `CHK(ws_load_data, 6'h2B)
    `CHK({op_refused, data_ram_we, data_wdata}, {2'b01, data_holding_reg})
    op(CTE_OP_NONE);
    $display("t_ops finished");
  endtask
  task automatic t_err;
    err(1'b1, 1'b0, 7'h55);
    rd(`CTE_SEL_ERR_CAP, 32'h5140_2345);
    err(1'b0, 1'b1, 7'h55);
    rd(`CTE_SEL_ERR_CAP, 32'hA88A_BCDE);
    err(1'b1, 1'b1, 7'h2A);
    rd(`CTE_SEL_ERR_CAP, 32'h2A81_2345);
    repeat (3) @(negedge ref_clk);
    rd(`CTE_SEL_ERR_CAP, 32'h2A81_2345);
    $display("t_err finished");
  endtask
  initial begin
    {cop_wr, ierr_valid, derr_valid, cop_sel, cop_wdata, ws_rdata} = '0;
    {cache_op, rst_n, ierr_way, derr_way} = {CTE_OP_NONE, 1'b0, 2'h1, 2'h2};
    {tag_holding_reg, data_holding_reg} = {32'h0001_AC00, 32'h1234_5678};
    {cache_index, ierr_index, derr_index} = {20'h0_0ABC, 20'h1_2345, 20'hA_BCDE};
    setf(7'h00);
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    t_regs;
    t_ops;
    t_err;
    wrap_up;
  end
  initial begin
    #5000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule // test_cache_test_and_error_capture
`default_nettype wire
